// File: rtl/uis_top.sv
// Unique id and parameter read command handling of a serial flash
// Assumes serial pins are asynchronous to clk and at least 8x slower
//
// What this block does
// [RULE1] Opcode 4Bh then 32 ignored dummy clocks
// [RULE2] Then 64-bit fixed id, one bit per fall
// [RULE3] Opcode 5Ah, 3 address bytes, dummy, rising edges
// [RULE4] Then table byte at address on falls
// [RULE5] Address steps by one after each byte
// [RULE6] Address wraps to zero past the top
// [RULE7] Select high ends read anytime, output released
// [RULE8] Parameter read refused while write cycle busy
// [RULE9] Bytes 00h-03h hold signature 53 46 44 50
// [RULE10] Revision minor 00h at 04h, major 01h at 05h
// [RULE11] 06h gives 00h header count, 07h FFh
// [RULE12] Header: maker code, revisions, length 09h
// [RULE13] Table pointer 000030h LSB first, then FFh
// [RULE14] Byte 30h: erase, write granularity, ones
// [RULE15] Byte 31h returns 4 KB erase opcode 20h
// [RULE16] Byte 32h read mode flags, 33h FFh
// [RULE17] Bytes 38h-39h: 1-4-4 waits, mode, EBh
// [RULE18] Bytes 3Ah-3Bh report 1-1-4 unsupported
// [RULE19] Bytes 3Ch-3Dh: 1-1-2 waits, opcode 3Bh
// [RULE20] Bytes 3Eh-3Fh: 1-2-2 waits, opcode BBh
// [RULE21] 4-4-4 flagged, waits, mode, opcode EBh
// [RULE22] 2-2-2 absent, reserved bytes read FFh
// [RULE23] Output undriven except during data phase
// [RULE24] Undefined table addresses read FFh
`timescale 1ns/1ps
`default_nettype none

module uis_top
    #(parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89AB_CDEF, // Value is arbitrary
      parameter logic [7:0]  MFR_CODE  = 8'hA5)                   // Value is arbitrary
(
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // Register port
    input  wire logic [uis_pkg::REG_AW-1:0] regAddr,
    input  wire logic [31:0]               regWdata,
    input  wire logic                      regWr,
    input  wire logic                      regRd,
    output logic      [31:0]               regRdata,
    // Flash core status
    input  wire logic                      writeBusy,
    // Serial pins
    input  wire logic                      spiSelN,
    input  wire logic                      spiClk,
    input  wire logic                      spiDin,
    output logic                           spiDout,
    output logic                           spiDoutOeN
);
    import uis_pkg::*;

    // ==============================
    // Pin synchronisers
    logic [2:0] pinIn;
    logic [2:0] syncA_r;
    logic [2:0] syncB_r;
    logic       clkD_r;

    assign pinIn = {spiSelN, spiClk, spiDin};

    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_sync
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    syncA_r[i] <= 1'b1;
                    syncB_r[i] <= 1'b1;
                end
                else
                begin
                    syncA_r[i] <= pinIn[i];
                    syncB_r[i] <= syncA_r[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            clkD_r <= 1'b1;
        else
            clkD_r <= syncB_r[1];
    end

    // ==============================
    // Edge and phase decode
    uis_state_e        state_r;
    uis_state_e        state_nxt;
    logic [5:0]        bitCnt_r;
    logic [5:0]        bitCnt_nxt;
    logic [7:0]        opc_r;
    logic              isUid_r;
    logic [SFDP_AW-1:0] addr_r;
    logic [63:0]       dataSr_r;
    logic              dout_r;
    logic              oeN_r;
    logic [1:0]        ctrl_r;
    logic              reject_r;
    logic [31:0]       rdata_r;

    wire        selHigh   = syncB_r[2];
    wire        sckLvl    = syncB_r[1];
    wire        din       = syncB_r[0];
    wire        sckRise   = sckLvl & ~clkD_r;
    wire        sckFall   = ~sckLvl & clkD_r;
    wire        inCmd     = (state_r == UIS_ST_CMD);
    wire        inAddr    = (state_r == UIS_ST_ADDR);
    wire        inDummy   = (state_r == UIS_ST_DUMMY);
    wire        inData    = (state_r == UIS_ST_DATA);
    wire        inHeader  = inCmd | inAddr | inDummy;
    wire [7:0]  opcNow    = {opc_r[6:0], din};
    wire        cmdDone   = inCmd & sckRise & (bitCnt_r == OPC_LAST);
    wire        addrDone  = inAddr & sckRise & (bitCnt_r == ADDR_LAST);
    wire [5:0]  dummyLast = isUid_r ? UID_DUMMY_LAST : SFDP_DUMMY_LAST;
    wire        dummyDone = inDummy & sckRise & (bitCnt_r == dummyLast);
    wire        phaseEnd  = cmdDone | addrDone | dummyDone;
    wire        byteEnd   = inData & sckFall & (bitCnt_r[2:0] == 3'h7);
    wire        isUidOpc  = (opcNow == OPC_UID);
    wire        isSfdpOpc = (opcNow == OPC_SFDP);
    wire        takeUid   = isUidOpc & ctrl_r[CTRL_UID_EN];
    wire        takeSfdp  = isSfdpOpc & ctrl_r[CTRL_SFDP_EN] & ~writeBusy; // [RULE8]
    wire        rejectNow = cmdDone & isSfdpOpc & writeBusy; // [RULE8]

    // ==============================
    // Command sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            UIS_ST_CMD:
            begin
                if (cmdDone)
                    state_nxt = takeUid ? UIS_ST_DUMMY : // [RULE1]
                                takeSfdp ? UIS_ST_ADDR : UIS_ST_SKIP; // [RULE3] [RULE8]
            end
            UIS_ST_ADDR:
            begin
                if (addrDone)
                    state_nxt = UIS_ST_DUMMY; // [RULE3]
            end
            UIS_ST_DUMMY:
            begin
                if (dummyDone)
                    state_nxt = UIS_ST_DATA; // [RULE1] [RULE3]
            end
            UIS_ST_DATA:
                state_nxt = UIS_ST_DATA;
            UIS_ST_SKIP:
                state_nxt = UIS_ST_SKIP;
            default:
                state_nxt = UIS_ST_CMD;
        endcase
        if (selHigh)
            state_nxt = UIS_ST_CMD; // [RULE7]
    end

    assign bitCnt_nxt = selHigh              ? 6'h00 :
                        phaseEnd             ? 6'h00 :
                        (inData & sckFall)   ? bitCnt_r + 6'h01 :
                        (inHeader & sckRise) ? bitCnt_r + 6'h01 :
                        bitCnt_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r  <= UIS_ST_CMD;
            bitCnt_r <= 6'h00;
        end
        else
        begin
            state_r  <= state_nxt;
            bitCnt_r <= bitCnt_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            opc_r   <= 8'h00;
            isUid_r <= 1'b0;
        end
        else if (inCmd & sckRise & ~selHigh)
        begin
            opc_r   <= opcNow;
            isUid_r <= isUidOpc;
        end
    end

    // ==============================
    // Address counter and table lookup
    uis_rom_if romIf ();

    assign romIf.addr = inData ? addr_r + 8'h01 : addr_r;

    uis_rom #(.MFR_CODE(MFR_CODE)) u_rom (
        .romIf (romIf)
    );

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            addr_r <= 8'h00;
        else if (inAddr & sckRise & ~selHigh)
            addr_r <= {addr_r[6:0], din}; // [RULE3]
        else if (byteEnd & ~isUid_r & ~selHigh)
            addr_r <= addr_r + 8'h01; // [RULE5] [RULE6]
    end

    // ==============================
    // Output shifter
    wire [63:0] sfdpLoad = {romIf.data, 56'h0};

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            dataSr_r <= 64'h0;
        else if (dummyDone & ~selHigh)
            dataSr_r <= isUid_r ? UNIQUE_ID : sfdpLoad; // [RULE2] [RULE4]
        else if (byteEnd & ~isUid_r & ~selHigh)
            dataSr_r <= sfdpLoad; // [RULE5]
        else if (inData & sckFall & ~selHigh)
            dataSr_r <= {dataSr_r[62:0], dataSr_r[63]}; // [RULE2]
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dout_r <= 1'b0;
            oeN_r  <= 1'b1;
        end
        else if (selHigh)
            oeN_r  <= 1'b1; // [RULE7] [RULE23]
        else if (inData & sckFall)
        begin
            dout_r <= dataSr_r[63]; // [RULE2] [RULE4]
            oeN_r  <= 1'b0; // [RULE23]
        end
    end

    assign spiDout    = dout_r;
    assign spiDoutOeN = oeN_r;

    // ==============================
    // Register port
    wire        ctrlWr   = regWr & (regAddr == REG_CTRL);
    wire        rejClr   = regWr & (regAddr == REG_STATUS) & regWdata[STAT_REJECT];
    wire [31:0] statWord = {15'h0, reject_r, addr_r, 2'h0, ~selHigh, state_r};
    wire [31:0] rdMux    = (regAddr == REG_CTRL)   ? {30'h0, ctrl_r} :
                           (regAddr == REG_STATUS) ? statWord :
                           (regAddr == REG_UID_LO) ? UNIQUE_ID[31:0] :
                           (regAddr == REG_UID_HI) ? UNIQUE_ID[63:32] :
                           32'h0;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_r   <= CTRL_RESET;
            reject_r <= 1'b0;
            rdata_r  <= RDATA_RESET;
        end
        else
        begin
            if (ctrlWr)
                ctrl_r <= regWdata[1:0];
            reject_r <= rejectNow | (reject_r & ~rejClr); // [RULE8]
            rdata_r  <= regRd ? rdMux : RDATA_RESET;
        end
    end

    assign regRdata = rdata_r;

    // ==============================
    // Checks
    logic [7:0] riseCnt_r;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            riseCnt_r <= 8'h00;
        else if (selHigh)
            riseCnt_r <= 8'h00;
        else if (sckRise & (riseCnt_r != RISE_SAT))
            riseCnt_r <= riseCnt_r + 8'h01;
    end

    a_uid_dummy_len: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
        (state_nxt == UIS_ST_DATA) && inDummy && isUid_r |-> riseCnt_r == PRE_DATA_RISES - 8'h01)
        else $error("unique id data began after wrong dummy count");

    a_sfdp_head_len: assert property (@(posedge clk) disable iff (!reset_n) // [RULE3]
        (state_nxt == UIS_ST_DATA) && inDummy && !isUid_r |-> riseCnt_r == PRE_DATA_RISES - 8'h01)
        else $error("parameter data began after wrong header length");

    a_data_msb_out: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
        inData && sckFall && !selHigh |=> spiDout == $past(dataSr_r[63]) && !spiDoutOeN)
        else $error("data bit not driven on falling edge");

    a_uid_id_order: assert property (@(posedge clk) disable iff (!reset_n) // [RULE2]
        dummyDone && isUid_r && !selHigh |=> dataSr_r == UNIQUE_ID)
        else $error("unique id not loaded for output");

    a_byte_addr_step: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
        byteEnd && !isUid_r && !selHigh |=> addr_r == $past(addr_r) + 8'h01)
        else $error("address did not step after byte");

    a_addr_wrap_zero: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
        byteEnd && !isUid_r && !selHigh && addr_r == ADDR_TOP |=> addr_r == 8'h00)
        else $error("address did not wrap to zero");

    a_sel_ends_read: assert property (@(posedge clk) disable iff (!reset_n) // [RULE7]
        selHigh |=> spiDoutOeN && state_r == UIS_ST_CMD)
        else $error("select high did not end the command");

    a_busy_refuse: assert property (@(posedge clk) disable iff (!reset_n) // [RULE8]
        cmdDone && isSfdpOpc && writeBusy && !selHigh |=> state_r == UIS_ST_SKIP ##1 reject_r)
        else $error("parameter read accepted while busy");

    a_oe_data_only: assert property (@(posedge clk) disable iff (!reset_n) // [RULE23]
        !spiDoutOeN |-> inData && !$past(selHigh))
        else $error("output driven outside data phase");

    a_sig_first: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
        dummyDone && !isUid_r && addr_r == 8'h00 && !selHigh |=> dataSr_r[63:56] == 8'h53)
        else $error("signature byte wrong at address zero");

    c_uid_data: cover property (@(posedge clk) disable iff (!reset_n)
        inData && isUid_r && bitCnt_r == 6'h3F && sckFall);
    c_sfdp_wrap: cover property (@(posedge clk) disable iff (!reset_n)
        byteEnd && !isUid_r && addr_r == ADDR_TOP);
    c_busy_reject: cover property (@(posedge clk) disable iff (!reset_n)
        rejectNow);
    c_mid_byte_end: cover property (@(posedge clk) disable iff (!reset_n)
        inData && selHigh && bitCnt_r[2:0] != 3'h0);

endmodule : uis_top

`default_nettype wire

// File: rtl/uis_pkg.sv
// Constants, types and offsets for the unique id and parameter reader
// Assumes a 100 MHz core clock and a slower serial host
package uis_pkg;

    // ==============================
    // Serial commands
    localparam logic [7:0] OPC_UID  = 8'h4B;
    localparam logic [7:0] OPC_SFDP = 8'h5A;

    // ==============================
    // Phase lengths as last bit index, rises before data, rise counter limit
    localparam logic [5:0] OPC_LAST        = 6'h07;
    localparam logic [5:0] ADDR_LAST       = 6'h17;
    localparam logic [5:0] UID_DUMMY_LAST  = 6'h1F;
    localparam logic [5:0] SFDP_DUMMY_LAST = 6'h07;
    localparam logic [7:0] PRE_DATA_RISES  = 8'h28;
    localparam logic [7:0] RISE_SAT        = 8'hFF;

    // ==============================
    // Parameter space
    localparam int         SFDP_AW   = 8;
    localparam logic [7:0] FILL_BYTE = 8'hFF;
    localparam logic [7:0] ADDR_TOP  = 8'hFF;

    // ==============================
    // Register port
    localparam int         REG_AW     = 8;
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_UID_LO = 8'h08;
    localparam logic [7:0] REG_UID_HI = 8'h0C;

    // ==============================
    // Field positions and reset values
    localparam int          CTRL_UID_EN  = 0;
    localparam int          CTRL_SFDP_EN = 1;
    localparam int          STAT_REJECT  = 16;
    localparam logic [1:0]  CTRL_RESET   = 2'h3;
    localparam logic [31:0] RDATA_RESET  = 32'h0000_0000;

    // ==============================
    // Command state, one-hot
    typedef enum logic [4:0] {
        UIS_ST_CMD   = 5'b00001,
        UIS_ST_ADDR  = 5'b00010,
        UIS_ST_DUMMY = 5'b00100,
        UIS_ST_DATA  = 5'b01000,
        UIS_ST_SKIP  = 5'b10000
    } uis_state_e;

endpackage : uis_pkg

// File: rtl/uis_rom_if.sv
// Lookup path between the command logic and the parameter table
// Assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none

interface uis_rom_if;
    logic [7:0] addr;
    logic [7:0] data;

    modport host (output addr, input data);
    modport rom  (input addr, output data);
endinterface : uis_rom_if

`default_nettype wire

// File: rtl/uis_rom.sv
// Fixed parameter table, one byte per address
// Assumes the reader holds the address steady while it loads
`timescale 1ns/1ps
`default_nettype none

module uis_rom
    #(parameter logic [7:0] MFR_CODE = 8'hA5) // Value is arbitrary
(
    // Lookup port
    uis_rom_if.rom romIf
);
    import uis_pkg::*;

    // ==============================
    // Table content
    function automatic logic [7:0] tableByte(input logic [7:0] a);
        logic [7:0] b;
        b = FILL_BYTE; // [RULE24]
        case (a)
            8'h00: b = 8'h53; // [RULE9]
            8'h01: b = 8'h46; // [RULE9]
            8'h02: b = 8'h44; // [RULE9]
            8'h03: b = 8'h50; // [RULE9]
            8'h04: b = 8'h00; // [RULE10]
            8'h05: b = 8'h01; // [RULE10]
            8'h06: b = 8'h00; // [RULE11]
            8'h07: b = 8'hFF; // [RULE11]
            8'h08: b = MFR_CODE; // [RULE12]
            8'h09: b = 8'h00; // [RULE12]
            8'h0A: b = 8'h01; // [RULE12]
            8'h0B: b = 8'h09; // [RULE12]
            8'h0C: b = 8'h30; // [RULE13]
            8'h0D: b = 8'h00; // [RULE13]
            8'h0E: b = 8'h00; // [RULE13]
            8'h0F: b = 8'hFF; // [RULE13]
            8'h30: b = 8'hE5; // [RULE14]
            8'h31: b = 8'h20; // [RULE15]
            8'h32: b = 8'hB1; // [RULE16]
            8'h33: b = 8'hFF; // [RULE16]
            8'h34: b = 8'hFF;
            8'h35: b = 8'hFF;
            8'h36: b = 8'hFF;
            8'h37: b = 8'h03;
            8'h38: b = 8'h46; // [RULE17]
            8'h39: b = 8'hEB; // [RULE17]
            8'h3A: b = 8'h00; // [RULE18]
            8'h3B: b = 8'hFF; // [RULE18]
            8'h3C: b = 8'h08; // [RULE19]
            8'h3D: b = 8'h3B; // [RULE19]
            8'h3E: b = 8'h04; // [RULE20]
            8'h3F: b = 8'hBB; // [RULE20]
            8'h40: b = 8'hEF; // [RULE21] [RULE22]
            8'h46: b = 8'h00; // [RULE22]
            8'h47: b = 8'hFF; // [RULE22]
            8'h4A: b = 8'h46; // [RULE21]
            8'h4B: b = 8'hEB; // [RULE21]
            8'h4C: b = 8'h0C;
            8'h4D: b = 8'h20;
            8'h4E: b = 8'h0F;
            8'h4F: b = 8'h52;
            8'h50: b = 8'h10;
            8'h51: b = 8'hD8;
            8'h52: b = 8'h00;
            default: b = FILL_BYTE; // [RULE22] [RULE24]
        endcase
        return b;
    endfunction : tableByte

    assign romIf.data = tableByte(romIf.addr);

endmodule : uis_rom

`default_nettype wire

// File: testbench/uis_host_model.sv
// Behavioural serial host for the unique id and parameter reader
// Assumes the device drives data after falls and is sampled on rises
`timescale 1ns/1ps
`default_nettype none

module uis_host_model
(
    // Serial pins
    output var logic spiSelN,
    output var logic spiClk,
    output var logic spiDin,
    input  wire logic spiDout,
    input  wire logic spiDoutOeN
);
    logic got[$];
    int   oeErr;

    initial
    begin
        spiSelN = 1'b1;
        spiClk  = 1'b0;
        spiDin  = 1'b0;
        oeErr   = 0;
    end

    // ==============================
    // One 125 ns clock, sample on the rise
    task automatic shift(input logic b, input logic expOeN);
        spiDin = b;
        #62.5;
        spiClk = 1'b1;
        if (spiDoutOeN !== expOeN)
            oeErr++;
        // Released line reads inverted
        got.push_back(spiDoutOeN ? ~spiDout : spiDout);
        #62.5;
        spiClk = 1'b0;
    endtask : shift

    // ==============================
    // Whole frame; clock stands low outside it
    task automatic frame(input logic [7:0] opc, input logic [23:0] adr, input int nAdr,
                         input int nDum, input int nOut, input logic en);
        int i;
        if (spiDoutOeN !== 1'b1)
            oeErr++;
        spiSelN = 1'b0;
        #50;
        for (i = 7; i >= 0; i--)
            shift(opc[i], 1'b1);
        for (i = nAdr - 1; i >= 0; i--)
            shift(adr[i], 1'b1);
        for (i = 0; i < nDum; i++)
            shift(~spiDin, 1'b1);
        got.delete();
        for (i = 0; i < nOut; i++)
            shift(~spiDin, ~en);
        #50;
        spiSelN = 1'b1;
        #100;
        if (spiDoutOeN !== 1'b1)
            oeErr++;
    endtask : frame
endmodule : uis_host_model

`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the unique id and parameter reader
// Assumes the host model drives the serial pins, the bench the rest
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import uis_pkg::*;

    localparam logic [63:0] TB_ID  = 64'h5A3C_96E1_0F2D_B478; // Value is arbitrary
    localparam logic [7:0]  TB_MFR = 8'hC3;                   // Value is arbitrary

    logic              clk;
    logic              reset_n;
    logic [REG_AW-1:0] regAddr;
    logic [31:0]       regWdata;
    logic              regWr;
    logic              regRd;
    logic [31:0]       regRdata;
    logic              writeBusy;
    logic              spiSelN;
    logic              spiClk;
    logic              spiDin;
    logic              spiDout;
    logic              spiDoutOeN;
    logic [31:0]       rd;
    logic [23:0]       start;
    int                n_errors;
    int                cmp_count;
    int                seed;

    uis_top #(.UNIQUE_ID(TB_ID), .MFR_CODE(TB_MFR)) u_uis_top (
        .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .writeBusy(writeBusy), .spiSelN(spiSelN),
        .spiClk(spiClk), .spiDin(spiDin), .spiDout(spiDout), .spiDoutOeN(spiDoutOeN));

    uis_host_model u_uis_host_model (
        .spiSelN(spiSelN), .spiClk(spiClk), .spiDin(spiDin), .spiDout(spiDout),
        .spiDoutOeN(spiDoutOeN));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ==============================
    // Checking and reporting
    task automatic conclude;
        $display("Checks %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    task automatic cmpReg(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %0t word %h expected %h", $time, g, e);
        end
    endtask : cmpReg

    task automatic cmpBit(input logic g, input logic e, input int k);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("[ERR] %0t serial bit %0d is %b expected %b", $time, k, g, e);
        end
    endtask : cmpBit

    task automatic endTest(input string name);
        cmpReg(32'(u_uis_host_model.oeErr), 32'h0);
        $display("Test %s done", name);
    endtask : endTest

    // ==============================
    // Register port master
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr    <= 1'b0;
    endtask : regWrite

    task automatic regRead(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask : regRead

    // ==============================
    // Expected parameter bytes
    function automatic logic [7:0] sfdpByte(input logic [7:0] a);
        case (a)
            8'h00: return 8'h53;
            8'h01: return 8'h46;
            8'h02: return 8'h44;
            8'h03: return 8'h50;
            8'h04, 8'h06, 8'h09, 8'h0D, 8'h0E: return 8'h00;
            8'h3A, 8'h46, 8'h52: return 8'h00;
            8'h05, 8'h0A: return 8'h01;
            8'h08: return TB_MFR;
            8'h0B: return 8'h09;
            8'h0C: return 8'h30;
            8'h30: return 8'hE5;
            8'h31, 8'h4D: return 8'h20;
            8'h32: return 8'hB1;
            8'h37: return 8'h03;
            8'h38, 8'h4A: return 8'h46;
            8'h39, 8'h4B: return 8'hEB;
            8'h3C: return 8'h08;
            8'h3D: return 8'h3B;
            8'h3E: return 8'h04;
            8'h3F: return 8'hBB;
            8'h40: return 8'hEF;
            8'h4C: return 8'h0C;
            8'h4E: return 8'h0F;
            8'h4F: return 8'h52;
            8'h50: return 8'h10;
            8'h51: return 8'hD8;
            default: return FILL_BYTE;
        endcase
    endfunction : sfdpByte

    task automatic chkSfdp(input logic [7:0] a, input int n);
        int         i;
        logic [7:0] b;
        cmpReg(32'(u_uis_host_model.got.size()), 32'(n));
        for (i = 0; i < n; i++)
        begin
            b = sfdpByte(8'(a + i / 8));
            cmpBit(u_uis_host_model.got[i], b[7 - i % 8], i);
        end
    endtask : chkSfdp

    // ==============================
    // Main sequence
    initial
    begin
        seed      = 32'hb0f9c433;
        n_errors  = 0;
        cmp_count = 0;
        reset_n   = 1'b0;
        regAddr   = '0;
        regWdata  = '0;
        regWr     = 1'b0;
        regRd     = 1'b0;
        writeBusy = 1'b0;
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        repeat (5) @(posedge clk);

        regRead(REG_CTRL, rd);
        cmpReg(rd, 32'(CTRL_RESET));
        @(posedge clk);
        #1;
        cmpReg(regRdata, 32'h0);
        regRead(REG_UID_LO, rd);
        cmpReg(rd, TB_ID[31:0]);
        regRead(REG_UID_HI, rd);
        cmpReg(rd, TB_ID[63:32]);
        regWrite(REG_UID_LO, ~TB_ID[31:0]);
        regRead(REG_UID_LO, rd);
        cmpReg(rd, TB_ID[31:0]);
        regRead(8'h10, rd);
        cmpReg(rd, 32'h0);
        endTest("registers");

        u_uis_host_model.frame(OPC_UID, 24'h0, 0, 32, 72, 1'b1);
        cmpReg(32'(u_uis_host_model.got.size()), 32'd72);
        for (int i = 0; i < 72; i++)
            cmpBit(u_uis_host_model.got[i], TB_ID[63 - i % 64], i);
        endTest("unique id");

        start = 24'($random(seed));
        u_uis_host_model.frame(OPC_SFDP, start, 24, 8, 2080, 1'b1);
        chkSfdp(start[7:0], 2080);
        start = {16'($random(seed)), 8'hFE};
        u_uis_host_model.frame(OPC_SFDP, start, 24, 8, 32, 1'b1);
        chkSfdp(8'hFE, 32);
        repeat (3)
        begin
            start = 24'($random(seed));
            u_uis_host_model.frame(OPC_SFDP, start, 24, 8, 24, 1'b1);
            chkSfdp(start[7:0], 24);
        end
        u_uis_host_model.frame(OPC_SFDP, 24'h000030, 24, 8, 13, 1'b1);
        chkSfdp(8'h30, 13);
        endTest("parameter read");

        @(posedge clk);
        writeBusy <= 1'b1;
        u_uis_host_model.frame(OPC_SFDP, 24'h0, 24, 8, 16, 1'b0);
        regRead(REG_STATUS, rd);
        cmpReg(32'(rd[STAT_REJECT]), 32'h1);
        cmpReg(32'(rd[5:0]), 32'h01);
        regWrite(REG_STATUS, 32'h1 << STAT_REJECT);
        regRead(REG_STATUS, rd);
        cmpReg(32'(rd[STAT_REJECT]), 32'h0);
        @(posedge clk);
        writeBusy <= 1'b0;
        u_uis_host_model.frame(OPC_SFDP, 24'h0, 24, 8, 32, 1'b1);
        chkSfdp(8'h00, 32);
        endTest("busy reject");

        regWrite(REG_CTRL, 32'h0);
        u_uis_host_model.frame(OPC_UID, 24'h0, 0, 32, 16, 1'b0);
        u_uis_host_model.frame(OPC_SFDP, 24'h0, 24, 8, 16, 1'b0);
        regWrite(REG_CTRL, 32'(CTRL_RESET));
        u_uis_host_model.frame(8'h03, 24'h0, 24, 8, 16, 1'b0);
        endTest("disabled and unknown");
        conclude();
    end

    initial
    begin
        #800000;
        n_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
endmodule : tb_top

`default_nettype wire
